/* pkg/acm_pkg.sv */
// audio port clock monitor: shared constants, enums and the sample carrier
// assumes one 200 MHz system clock; all serial pins are asynchronous to it
package acm_pkg;

  // ==========================================================
  // clocking and timing
  localparam int CLK_NS     = 5;       // clk_sys period
  localparam int HALT_NS    = 50000;   // silence on a clock pin that counts as a halt
  localparam int HALT_CYC   = (HALT_NS + CLK_NS - 1) / CLK_NS;
  // frame period windows per rate class, in ns
  localparam int R32_MIN_NS = 27000;
  localparam int R32_MAX_NS = 36000;
  localparam int R48_MIN_NS = 16000;
  localparam int R96_MIN_NS = 9000;
  localparam int R32_MIN    = (R32_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int R32_MAX    = R32_MAX_NS / CLK_NS;
  localparam int R48_MIN    = (R48_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int R96_MIN    = (R96_MIN_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // field widths and sizes
  localparam int CNT_W      = 16;      // idle and period counters
  localparam int RATIO_W    = 10;      // bit clocks per frame, up to 1023
  localparam int WORD_W     = 32;      // longest accepted audio word
  localparam int CHAN_W     = 4;       // stereo side or tdm slot index
  localparam int TDM_SLOT   = 32;      // bits per tdm slot
  localparam int FIFO_DEPTH = 8;

  // supported bit clock to word clock ratios
  localparam logic [RATIO_W-1:0] RAT_32  = 10'h020;
  localparam logic [RATIO_W-1:0] RAT_64  = 10'h040;
  localparam logic [RATIO_W-1:0] RAT_128 = 10'h080;
  localparam logic [RATIO_W-1:0] RAT_256 = 10'h100;
  localparam logic [RATIO_W-1:0] RAT_512 = 10'h200;

  // ==========================================================
  // enumerations
  typedef enum logic [1:0] {
    FMT_I2S = 2'b00,
    FMT_LJ  = 2'b01,
    FMT_RJ  = 2'b10,
    FMT_TDM = 2'b11
  } acm_fmt_e;

  typedef enum logic [1:0] {
    WL_16 = 2'b00,
    WL_20 = 2'b01,
    WL_24 = 2'b10,
    WL_32 = 2'b11
  } acm_wlen_e;

  typedef enum logic [2:0] {
    RATE_NONE = 3'b000,
    RATE_32K  = 3'b001,
    RATE_48K  = 3'b010,
    RATE_96K  = 3'b011,
    RATE_BAD  = 3'b100
  } acm_rate_e;

  typedef enum logic [1:0] {
    ST_LOCK = 2'b00,
    ST_PLAY = 2'b01,
    ST_HALT = 2'b10
  } acm_state_e;

  // one received audio word, left aligned, with its channel
  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic [WORD_W-1:0] data;
  } acm_sample_s;

  localparam int SAMPLE_W = CHAN_W + WORD_W;

endpackage

/* src/acm_fifo.sv */
// small first-in first-out buffer with a registered read side
// assumes both sides run on clk_sys; in_ready falls when all entries hold data
module acm_fifo
  import acm_pkg::*;
#(
  parameter int WIDTH = SAMPLE_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
    logic                        ov;
    logic [WIDTH-1:0]            od;
  } acm_fifo_st_s;

  acm_fifo_st_s q;
  acm_fifo_st_s next_q;
  logic         push;
  logic         load;

  // ==========================================================
  // storage and output stage
  assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid = q.ov;
  assign out_data  = q.od;

  // the output register refills as soon as it empties; a word is written one cycle and loaded the next, so two cycles of latency
  always_comb begin
    next_q = q;
    push   = in_valid && in_ready;
    load   = (q.cnt != '0) && (!q.ov || out_ready);
    if (push) begin
      next_q.mem[q.wr] = in_data;
      next_q.wr        = q.wr + 1'b1;
    end
    if (load) begin
      next_q.od = q.mem[q.rd];
      next_q.rd = q.rd + 1'b1;
    end
    next_q.ov  = load || (q.ov && !out_ready);
    next_q.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(load);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

endmodule

/* src/acm_port.sv */
// serial audio receive port with clock supervision
// assumes bit clock, word clock and data arrive asynchronously on pins; format and
// word length inputs are static levels from logic on clk_sys
// Notes on behaviour
// - every processing clock follows the bit clock
// - sense 32, 48 or 96 kHz class automatically
// - clock stop: sleep processor, amplifier outputs high-impedance
// - clocks back: resume play, settings kept
// - data bits sampled on bit clock rising edge
// - word clock: channel select, or tdm frame sync
// - stereo formats: 16-32 bits, 32 or 64 fs
// - tdm ratios depend on rate class
// - halt or bad ratio raises clock error
// - rate change mid-run is re-detected without reconfiguring
// - samples are two's complement, msb first, to 32 bits
// - tdm frame starts on word clock rising edge
module acm_port
  import acm_pkg::*;
#(
  parameter int HALT_CYCLES = HALT_CYC
) (
  input  wire logic    clk_sys,
  input  wire logic    rst,
  input  wire logic    bit_clk,
  input  wire logic    word_frame_sync,
  input  wire logic    serial_data_in,
  input  wire acm_fmt_e  fmt_sel,
  input  wire acm_wlen_e word_len,
  output logic         smp_valid,
  input  wire logic    smp_ready,
  output acm_sample_s  smp,
  output logic         clk_error,
  output logic         proc_sleep,
  output logic         amp_hiz,
  output logic         proc_clk_en,
  output acm_rate_e    fs_rate,
  output logic         overrun
);

  typedef struct packed {
    logic [2:0]         s1;       // pin synchroniser, first stage
    logic [2:0]         s2;
    logic [2:0]         s3;
    logic [2:0]         lvl;      // filtered pin levels
    acm_state_e         st;
    logic               wprev;    // word clock at previous bit clock rise
    logic               fprev;    // framing level at previous bit clock rise
    logic               in_word;
    logic [5:0]         bitcnt;
    logic [WORD_W-1:0]  sh;
    logic [CHAN_W-1:0]  chan;
    logic [CNT_W-1:0]   per_cnt;
    logic [RATIO_W-1:0] fbits;
    logic               seen;     // a frame start has opened the measurement
    logic [CNT_W-1:0]   b_idle;
    logic [CNT_W-1:0]   w_idle;
    acm_rate_e          lk_rate;
    logic [RATIO_W-1:0] lk_ratio;
    logic               push;
    acm_sample_s        push_smp;
    logic               clk_error;
    logic               proc_sleep;
    logic               amp_hiz;
    logic               proc_clk_en;
    logic               overrun;
  } acm_port_st_s;

  acm_port_st_s q;
  acm_port_st_s next_q;
  logic         fifo_ready;

  localparam logic [CNT_W-1:0] HALT_LIM = CNT_W'(HALT_CYCLES);

  // ==========================================================
  // helpers
  function automatic logic [5:0] wbits(input acm_wlen_e wl);
    case (wl)
      WL_16:   wbits = 6'h10;
      WL_20:   wbits = 6'h14;
      WL_24:   wbits = 6'h18;
      default: wbits = 6'h20;
    endcase
  endfunction

  // frame period in clk_sys cycles to rate class
  function automatic acm_rate_e classify(input logic [CNT_W-1:0] p);
    if (p >= CNT_W'(R32_MIN) && p <= CNT_W'(R32_MAX)) begin
      classify = RATE_32K;
    end else if (p >= CNT_W'(R48_MIN) && p < CNT_W'(R32_MIN)) begin
      classify = RATE_48K;
    end else if (p >= CNT_W'(R96_MIN) && p < CNT_W'(R48_MIN)) begin
      classify = RATE_96K;
    end else begin
      classify = RATE_BAD;
    end
  endfunction

  function automatic logic ratio_ok(input acm_rate_e r, input logic [RATIO_W-1:0] b,
                                    input logic tdm);
    if (r == RATE_BAD || r == RATE_NONE) begin
      ratio_ok = 1'b0;
    end else if (!tdm) begin
      ratio_ok = (b == RAT_32) || (b == RAT_64);
    end else begin
      case (r)
        RATE_32K: ratio_ok = (b == RAT_128);
        RATE_48K: ratio_ok = (b == RAT_128) || (b == RAT_256) || (b == RAT_512);
        default:  ratio_ok = (b == RAT_128) || (b == RAT_256);
      endcase
    end
  endfunction

  // ==========================================================
  // next state
  // pins pass three flops; a level counts once stages two and three agree
  always_comb begin
    logic        brise;
    logic        wchg;
    logic        tdm;
    logic        wcur;
    logic        dbit;
    logic        frame;
    logic        fstart;
    logic        bound;
    logic        halt;
    logic        meas;
    logic        ok;
    acm_rate_e   rate;
    logic [5:0]  wb;
    brise  = 1'b0;
    wchg   = 1'b0;
    tdm    = (fmt_sel == FMT_TDM);
    wcur   = q.s3[1];
    dbit   = q.s3[2];
    frame  = 1'b0;
    fstart = 1'b0;
    bound  = 1'b0;
    meas   = 1'b0;
    halt   = 1'b0;
    ok     = 1'b0;
    rate   = classify(q.per_cnt);
    wb     = wbits(word_len);
    next_q = q;
    next_q.s1 = {serial_data_in, word_frame_sync, bit_clk};
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    for (int i = 0; i < 3; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        next_q.lvl[i] = q.s3[i];
      end
    end
    brise = (q.s2[0] == q.s3[0]) && q.s3[0] && !q.lvl[0];
    wchg  = (q.s2[1] == q.s3[1]) && (q.s3[1] != q.lvl[1]);
    next_q.push        = 1'b0;
    next_q.overrun     = 1'b0;
    next_q.proc_clk_en = brise && (q.st == ST_PLAY);

    // idle timers restart on every edge of their pin
    next_q.b_idle  = (q.s2[0] != q.s3[0]) ? '0 :
                     (q.b_idle == HALT_LIM) ? q.b_idle : q.b_idle + 1'b1;
    next_q.w_idle  = wchg ? '0 : (q.w_idle == HALT_LIM) ? q.w_idle : q.w_idle + 1'b1;
    halt           = (q.b_idle == HALT_LIM) || (q.w_idle == HALT_LIM);
    next_q.per_cnt = (&q.per_cnt) ? q.per_cnt : q.per_cnt + 1'b1;

    // receive on each bit clock rise; i2s frames one bit after the word clock edge
    if (brise) begin
      frame        = (fmt_sel == FMT_I2S) ? q.wprev : wcur;
      fstart       = wcur && !q.wprev;
      bound        = tdm ? (fstart || q.bitcnt == 6'(TDM_SLOT)) : (frame != q.fprev);
      next_q.wprev = wcur;
      next_q.fprev = frame;
      if (bound) begin
        if (q.in_word && q.st == ST_PLAY) begin
          // msb first, left aligned so the sign bit lands in bit 31
          next_q.push_smp.data = q.sh << (6'(WORD_W) - wb);
          next_q.push_smp.chan = q.chan;
          next_q.push          = fifo_ready;
          next_q.overrun       = !fifo_ready;
        end
        next_q.in_word = 1'b1;
        next_q.bitcnt  = 6'h01;
        next_q.sh      = {{(WORD_W-1){1'b0}}, dbit};
        if (tdm) begin
          next_q.chan = fstart ? '0 : q.chan + 1'b1;
        end else begin
          next_q.chan = {3'h0, (fmt_sel == FMT_I2S) ? frame : !frame};
        end
      end else begin
        // right justified keeps the last bits, the others the first ones
        if (fmt_sel == FMT_RJ || q.bitcnt < wb) begin
          next_q.sh = {q.sh[WORD_W-2:0], dbit};
        end
        next_q.bitcnt = (&q.bitcnt) ? q.bitcnt : q.bitcnt + 1'b1;
      end
      if (fstart) begin
        meas           = q.seen;
        next_q.seen    = 1'b1;
        next_q.per_cnt = '0;
        next_q.fbits   = 10'h001;
      end else begin
        next_q.fbits = (&q.fbits) ? q.fbits : q.fbits + 1'b1;
      end
    end
    ok = ratio_ok(rate, q.fbits, tdm);

    // supervision: halt beats everything, a changed frame forces a new lock
    case (q.st)
      ST_LOCK: begin
        if (meas) begin
          next_q.lk_rate   = rate;
          next_q.lk_ratio  = q.fbits;
          next_q.clk_error = !ok;
          if (ok && rate == q.lk_rate && q.fbits == q.lk_ratio) begin
            next_q.st = ST_PLAY;
          end
        end
      end
      ST_PLAY: begin
        if (meas && (!ok || rate != q.lk_rate || q.fbits != q.lk_ratio)) begin
          next_q.st        = ST_LOCK;
          next_q.clk_error = !ok;
          next_q.lk_rate   = rate;
          next_q.lk_ratio  = q.fbits;
        end
      end
      ST_HALT: begin
        if (!halt) begin
          next_q.st = ST_LOCK;
        end
      end
      default: begin
        next_q.st = ST_LOCK;
      end
    endcase
    if (halt) begin
      next_q.st        = ST_HALT;
      next_q.clk_error = 1'b1;
      next_q.seen      = 1'b0;
      next_q.in_word   = 1'b0;
      next_q.lk_rate   = RATE_NONE;
    end
    next_q.proc_sleep = (next_q.st == ST_HALT);
    next_q.amp_hiz    = (next_q.st != ST_PLAY);
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q            <= '0;
      q.st         <= ST_LOCK;
      q.lk_rate    <= RATE_NONE;
      q.amp_hiz    <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================
  // sample buffer; the serial link cannot stall, so a full buffer drops and flags
  acm_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (q.push),
    .in_ready  (fifo_ready),
    .in_data   (q.push_smp),
    .out_valid (smp_valid),
    .out_ready (smp_ready),
    .out_data  (smp)
  );

  assign clk_error   = q.clk_error;
  assign proc_sleep  = q.proc_sleep;
  assign amp_hiz     = q.amp_hiz;
  assign proc_clk_en = q.proc_clk_en;
  assign fs_rate     = q.lk_rate;
  assign overrun     = q.overrun;

endmodule

/* tb/acm_host.sv */
// audio source model: bit clock 160 ns, word clock and serial data
// assumes fmt and ratio only change while run is low
module acm_host
  import acm_pkg::*;
(
  input  wire logic [RATIO_W-1:0] run_ratio,
  input  wire logic               run,
  input  wire acm_fmt_e           fmt,
  input  wire logic [WORD_W-1:0]  word,
  output logic                    bit_clk,
  output logic                    word_frame_sync,
  output logic                    serial_data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  int n;
  int j;
  int half;

  // ==========
  // pins move only while run is high; stopped clocks stand still and the
  // data line flips so a stale bit is never mistaken for a driven one
  initial begin
    bit_clk = 1'b0;
    word_frame_sync = 1'b0;
    serial_data_in = 1'b0;
    n = 0;
    forever begin
      // an unknown run at time zero counts as stopped, so no stray edge leaves the model
      if (run !== 1'b1) begin
        n = 0;
        serial_data_in = ~serial_data_in;
        wait (run);
      end
      half = (fmt == FMT_TDM) ? TDM_SLOT : run_ratio / 2;
      j = (fmt == FMT_I2S) ? (n + half - 1) % half : n % half;
      word_frame_sync = (fmt == FMT_I2S) ? n >= run_ratio / 2 : n < run_ratio / 2;
      serial_data_in = word[WORD_W - 1 - j];
      #80 bit_clk = 1'b1;
      #80 bit_clk = 1'b0;
      n = (n + 1) % run_ratio;
    end
  end
endmodule

/* tb/acm_port_monitor.sv */
// checker for acm_port: clock pin activity against halt, play and sample outputs
// assumes one clk_sys domain; bound into every acm_port instance below
module acm_port_monitor
  import acm_pkg::*;
#(
  parameter int HALT_CYCLES = HALT_CYC
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        bit_clk,
  input wire logic        word_frame_sync,
  input wire logic        smp_valid,
  input wire logic        smp_ready,
  input wire acm_sample_s smp,
  input wire logic        clk_error,
  input wire logic        proc_sleep,
  input wire logic        amp_hiz,
  input wire logic        proc_clk_en,
  input wire acm_rate_e   fs_rate,
  input wire logic        overrun
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] idle_b;
  logic [15:0] idle_w;
  logic [1:0]  pins;

  // ==========
  // idle counts per clock pin: a halt is due when either pin alone goes quiet, so
  // one shared count would miss a halt of a word clock that the bit clock outlived
  always_ff @(posedge clk_sys) begin
    pins <= {bit_clk, word_frame_sync};
    if (rst || pins[1] != bit_clk) begin
      idle_b <= 16'h0;
    end else if (idle_b != 16'hffff) begin
      idle_b <= idle_b + 16'h1;
    end
    if (rst || pins[0] != word_frame_sync) begin
      idle_w <= 16'h0;
    end else if (idle_w != 16'hffff) begin
      idle_w <= idle_w + 16'h1;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ==========
  // halt and recovery
  property p_sleep; proc_sleep |-> amp_hiz && clk_error && fs_rate == RATE_NONE; endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep without hiz, error or cleared rate");
  property p_late;
    idle_b == 16'(HALT_CYCLES + 8) || idle_w == 16'(HALT_CYCLES + 8) |-> proc_sleep;
  endproperty
  a_late: assert property (p_late)
    else $error("silent pins but no halt");
  property p_early;
    $rose(proc_sleep) |-> idle_b >= 16'(HALT_CYCLES) || idle_w >= 16'(HALT_CYCLES);
  endproperty
  a_early: assert property (p_early)
    else $error("halt declared too early");
  property p_resume;
    $fell(proc_sleep) |-> amp_hiz && (idle_b < 16'h8 || idle_w < 16'h8);
  endproperty
  a_resume: assert property (p_resume)
    else $error("wake without pin activity or straight to play");

  // ==========
  // play state, rate and sample port
  property p_play; !amp_hiz |-> !clk_error && fs_rate inside {RATE_32K, RATE_48K, RATE_96K};
  endproperty
  a_play: assert property (p_play)
    else $error("playing with error or no rate class");
  property p_bad; fs_rate == RATE_BAD |-> clk_error && amp_hiz; endproperty
  a_bad: assert property (p_bad)
    else $error("bad rate without clock error");
  property p_pulse; proc_clk_en |=> !proc_clk_en [*8]; endproperty
  a_pulse: assert property (p_pulse)
    else $error("processing enable faster than bit clock");
  property p_hold; smp_valid && !smp_ready |=> smp_valid && $stable(smp); endproperty
  a_hold: assert property (p_hold)
    else $error("sample changed while stalled");

  c_play: cover property ($fell(amp_hiz));
  c_halt: cover property ($rose(proc_sleep));
  c_ovr: cover property (overrun);
endmodule

bind acm_port acm_port_monitor #(.HALT_CYCLES(HALT_CYCLES)) u_mon (
  .clk_sys(clk_sys), .rst(rst), .bit_clk(bit_clk), .word_frame_sync(word_frame_sync),
  .smp_valid(smp_valid), .smp_ready(smp_ready), .smp(smp), .clk_error(clk_error),
  .proc_sleep(proc_sleep), .amp_hiz(amp_hiz), .proc_clk_en(proc_clk_en),
  .fs_rate(fs_rate), .overrun(overrun)
);

/* tb/acm_port_tb.sv */
// bench for acm_port: host model drives the pins, tasks judge the outputs
// assumes halt timeout shortened to 2500 cycles so each halt fits the run
module acm_port_tb
  import acm_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam int          HALT_SIM = 2500;
  localparam logic [31:0] WORD     = 32'hc3a5_5a3c;  // negative sample
  logic        clk_sys, rst, smp_ready, run, bit_clk, word_frame_sync, serial_data_in;
  logic        smp_valid, clk_error, proc_sleep, amp_hiz, overrun, proc_clk_en;
  logic [9:0]  ratio;
  acm_fmt_e    fmt_sel;
  acm_wlen_e   word_len;
  acm_sample_s smp;
  acm_rate_e   fs_rate;
  int          n_errors = 0;
  int          n_checks = 0;

  acm_port #(.HALT_CYCLES(HALT_SIM)) uut (
    .clk_sys(clk_sys), .rst(rst), .bit_clk(bit_clk), .word_frame_sync(word_frame_sync),
    .serial_data_in(serial_data_in), .fmt_sel(fmt_sel), .word_len(word_len),
    .smp_valid(smp_valid), .smp_ready(smp_ready), .smp(smp), .clk_error(clk_error),
    .proc_sleep(proc_sleep), .amp_hiz(amp_hiz), .proc_clk_en(proc_clk_en), .fs_rate(fs_rate),
    .overrun(overrun));
  acm_host host (.run_ratio(ratio), .run(run), .fmt(fmt_sel), .word(WORD),
    .bit_clk(bit_clk), .word_frame_sync(word_frame_sync), .serial_data_in(serial_data_in));

  // ==========
  // 200 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // take one word; read at the falling edge so registered outputs have settled, and
  // never in the rising edge's time step, where the word just taken still shows
  task automatic get(output acm_sample_s s);
    int k;
    @(negedge clk_sys);
    for (k = 0; k < 5000 && smp_valid !== 1'b1; k++) @(negedge clk_sys);
    check("smp_valid", smp_valid, 1'b1);
    s = smp;
    @(posedge clk_sys);
  endtask

  task automatic t_halt();
    int k;
    @(posedge clk_sys);
    run <= 1'b0;
    for (k = 0; k < HALT_SIM + 200 && proc_sleep !== 1'b1; k++) @(negedge clk_sys);
    check("proc_sleep", proc_sleep, 1'b1);
    check("amp_hiz", amp_hiz, 1'b1);
    check("clk_error", clk_error, 1'b1);
    $display("test halt done");
  endtask

  task automatic t_play(input acm_fmt_e f, input acm_wlen_e wl, input logic [9:0] r,
                        input acm_rate_e rate, input int nch, input logic [31:0] exp);
    acm_sample_s s;
    logic [3:0]  c;
    int          k;
    int          n;
    @(posedge clk_sys);
    fmt_sel  <= f;
    word_len <= wl;
    ratio    <= r;
    run      <= 1'b1;
    for (k = 0; k < 20000 && amp_hiz !== 1'b0; k++) @(negedge clk_sys);
    check("amp_hiz", amp_hiz, 1'b0);
    check("fs_rate", fs_rate, rate);
    check("clk_error", clk_error, 1'b0);
    // bit clock is 32 system cycles, so ten bit clocks give exactly ten enables
    n = 0;
    for (k = 0; k < 320; k++) begin
      @(negedge clk_sys);
      n += (proc_clk_en === 1'b1);
    end
    check("proc_clk_en", n, 10);
    get(s);
    for (k = 0; k < 2; k++) begin
      c = s.chan;
      get(s);
      check("chan", s.chan, 4'((c + 1) % nch));
      check("data", s.data, exp);
    end
    $display("test play format %0d done", f);
  endtask

  // ratio 32 at this bit clock gives a frame rate outside every class
  task automatic t_bad();
    int k;
    @(posedge clk_sys);
    fmt_sel <= FMT_I2S;
    ratio   <= 10'h020;
    run     <= 1'b1;
    for (k = 0; k < 8000 && fs_rate !== RATE_BAD; k++) @(negedge clk_sys);
    check("fs_rate", fs_rate, RATE_BAD);
    check("clk_error", clk_error, 1'b1);
    check("amp_hiz", amp_hiz, 1'b1);
    $display("test bad ratio done");
  endtask

  // stall the sink until a word is dropped, stop the clocks, then drain
  task automatic t_fill();
    int k;
    int n;
    @(posedge clk_sys);
    smp_ready <= 1'b0;
    for (k = 0; k < 15000 && overrun !== 1'b1; k++) @(negedge clk_sys);
    check("overrun", overrun, 1'b1);
    @(posedge clk_sys);
    run       <= 1'b0;
    smp_ready <= 1'b1;
    n = 0;
    for (k = 0; k < 40; k++) begin
      @(negedge clk_sys);
      n += (smp_valid === 1'b1);
    end
    check("drained", n, FIFO_DEPTH + 1);
    $display("test fill done");
  endtask

  // ==========
  // main sequence
  initial begin
    rst = 1'b1;
    run = 1'b0;
    smp_ready = 1'b1;
    ratio = 10'h040;
    fmt_sel = FMT_I2S;
    word_len = WL_32;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check("amp_hiz", amp_hiz, 1'b1);
    check("fs_rate", fs_rate, RATE_NONE);
    check("smp_valid", smp_valid, 1'b0);
    $display("test reset done");
    t_halt();
    t_play(FMT_I2S, WL_24, 10'h040, RATE_96K, 2, {WORD[31:8], 8'h0});
    t_halt();
    t_play(FMT_LJ, WL_32, 10'h040, RATE_96K, 2, WORD);
    t_halt();
    t_play(FMT_RJ, WL_16, 10'h040, RATE_96K, 2, {WORD[15:0], 16'h0});
    t_halt();
    t_bad();
    t_halt();
    t_play(FMT_TDM, WL_20, 10'h080, RATE_48K, 4, {WORD[31:12], 12'h0});
    t_fill();
    t_halt();
    final_report();
  end

  // ==========
  // watchdog: the whole sequence needs about 65000 cycles
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_errors++;
    final_report();
  end
endmodule
